// file: logic/sbsc_cycle_ctrl.sv
// holds the cycle decode, burst counter, storage array and data pin control of a
// synchronous burst static ram with common data i/o and two byte lanes
// assumes bus pins are launched on core_clk by the host; only sleepRequest is asynchronous
// and outputEnableN acts on the data pins without any clocking
//
// Notes on behaviour
// - write active: global low, or byte-enable plus lane
// - write inactive otherwise, treated as a read
// - processor strobe with selects always begins read
// - writes follow controller strobe, never processor strobe
// - output enable acts asynchronously on pin drive
// - write cycles release data pins, ignoring enable
// - read pins released when enable high or deselected
// - read with enable low drives read data
// - begin read from external address on strobes
// - controller strobe plus write begins write burst
// - no strobe, advance low, read: next address
// - no strobe, advance low, write: next address
// - no strobe, advance high, read: hold address
// - no strobe, advance high, write: hold address
// - sleep ignores inputs, releases pins, keeps contents
// - two-bit counter, linear or interleaved order
// - processor strobe ignored while select a high
`timescale 1ns/1ps
module sbsc_cycle_ctrl #(
    parameter int ADDR_W     = sbsc_pkg::ADDR_W,
    parameter int WBUF_DEPTH = sbsc_pkg::WBUF_DEPTH
) (
    // clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        arst_n,
    // selects and sleep
    input  wire logic                        chipSelAN,
    input  wire logic                        chipSelB,
    input  wire logic                        chipSelCN,
    input  wire logic                        sleepRequest,
    // address and burst control
    input  wire logic [ADDR_W-1:0]           address,
    input  wire logic                        procAddrStrobe,
    input  wire logic                        ctrlAddrStrobe,
    input  wire logic                        burstAdvance,
    input  wire logic                        burstMode,
    // write control
    input  wire logic                        globalWrite,
    input  wire logic                        byteWriteEnableN,
    input  wire logic                        lane0WriteSel,
    input  wire logic                        lane1WriteSel,
    // output enable
    input  wire logic                        outputEnableN,
    // data pins
    input  wire logic [sbsc_pkg::DATA_W-1:0] dataIn,
    output logic [sbsc_pkg::DATA_W-1:0]      dataOut,
    output logic                             dataOe,
    // parity pins
    input  wire logic [sbsc_pkg::LANES-1:0]  parityIn,
    output logic [sbsc_pkg::LANES-1:0]      parityOut,
    output logic                             parityOe,
    // status
    output logic                             writeBufReady,
    output logic                             asleep
);
    localparam int DATA_W  = sbsc_pkg::DATA_W;
    localparam int LANES   = sbsc_pkg::LANES;
    localparam int LANE_W  = sbsc_pkg::LANE_W;
    localparam int BURST_W = sbsc_pkg::BURST_W;
    localparam int WORDS   = 1 << ADDR_W;
    localparam int ENTRY_W = $bits(sbsc_pkg::sbsc_wr_t);

    // sleep synchroniser and level
    logic [sbsc_pkg::SYNC_STAGES-1:0] sleepSync_r;
    logic                             sleepLvl_r;
    logic                             sleepLvl_nxt;

    // burst state
    logic                             burstActive_r;
    logic [ADDR_W-1:BURST_W]          addrHigh_r;
    logic [BURST_W-1:0]               addrBase_r;
    logic [BURST_W-1:0]               burstCnt_r;
    logic [BURST_W-1:0]               burstCnt_nxt;

    // read path
    logic [DATA_W-1:0]                dataOut_r;
    logic [LANES-1:0]                 parityOut_r;
    logic                             readCycle_r;

    // storage
    logic [LANE_W-1:0]                laneMem   [LANES][WORDS];
    logic                             parityMem [LANES][WORDS];

    // decode
    sbsc_pkg::sbsc_cycle_t            cycle;
    logic                             writeAct;
    logic                             selectsOk;
    logic                             procStrobe;
    logic                             ctrlStrobe;
    logic                             isBegin;
    logic                             isNext;
    logic                             isRead;
    logic                             isWrite;
    logic [BURST_W-1:0]               cntUse;
    logic [ADDR_W-1:0]                accessAddr;
    logic [LANES-1:0]                 laneEn;

    // write buffer
    sbsc_pkg::sbsc_wr_t               wrEntry;
    sbsc_pkg::sbsc_wr_t               headEntry;
    logic [ENTRY_W-1:0]               headBits;
    logic                             headValid;
    logic                             drainReady;
    logic                             pushValid;
    logic                             headHit;

    // next burst position in the selected order
    function automatic logic [BURST_W-1:0] burstLow(
        input logic [BURST_W-1:0] base,
        input logic [BURST_W-1:0] cnt,
        input logic               interleaved
    );
        burstLow = interleaved ? (base ^ cnt) : (base + cnt);
    endfunction

    // sleep pin is asynchronous: three stages, level moves once the last two agree
    assign sleepLvl_nxt = (sleepSync_r[1] == sleepSync_r[2]) ? sleepSync_r[2] : sleepLvl_r;
    assign asleep       = sleepLvl_r;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sleepSync_r <= '0;
            sleepLvl_r  <= 1'b0;
        end else begin
            sleepSync_r <= {sleepSync_r[1:0], sleepRequest};
            sleepLvl_r  <= sleepLvl_nxt;
        end
    end

    // combined write indication
    assign writeAct = ~globalWrite
                    | (~byteWriteEnableN & (~lane0WriteSel | ~lane1WriteSel));

    assign laneEn[0] = ~globalWrite | (~byteWriteEnableN & ~lane0WriteSel);
    assign laneEn[1] = ~globalWrite | (~byteWriteEnableN & ~lane1WriteSel);

    assign selectsOk  = ~chipSelAN & chipSelB & ~chipSelCN;
    assign procStrobe = ~procAddrStrobe & ~chipSelAN;
    assign ctrlStrobe = ~ctrlAddrStrobe & ~procStrobe;

    // cycle decode; a full write buffer does not enter the decode, and a write that meets it is dropped
    always_comb begin
        cycle = sbsc_pkg::CYC_IDLE;
        if (sleepLvl_r) begin
            cycle = sbsc_pkg::CYC_SLEEP;
        end else if (procStrobe) begin
            if (selectsOk) begin
                cycle = sbsc_pkg::CYC_RD_BEGIN;
            end else begin
                cycle = sbsc_pkg::CYC_DESEL;
            end
        end else if (ctrlStrobe) begin
            if (!selectsOk) begin
                cycle = sbsc_pkg::CYC_DESEL;
            end else if (writeAct) begin
                cycle = sbsc_pkg::CYC_WR_BEGIN;
            end else begin
                cycle = sbsc_pkg::CYC_RD_BEGIN;
            end
        end else if (burstActive_r) begin
            case ({burstAdvance, writeAct})
                2'b00:   cycle = sbsc_pkg::CYC_RD_NEXT;
                2'b01:   cycle = sbsc_pkg::CYC_WR_NEXT;
                2'b10:   cycle = sbsc_pkg::CYC_RD_HOLD;
                2'b11:   cycle = sbsc_pkg::CYC_WR_HOLD;
                default: cycle = sbsc_pkg::CYC_IDLE;
            endcase
        end
    end

    assign isBegin = (cycle == sbsc_pkg::CYC_RD_BEGIN) | (cycle == sbsc_pkg::CYC_WR_BEGIN);
    assign isNext  = (cycle == sbsc_pkg::CYC_RD_NEXT)  | (cycle == sbsc_pkg::CYC_WR_NEXT);
    assign isRead  = (cycle == sbsc_pkg::CYC_RD_BEGIN) | (cycle == sbsc_pkg::CYC_RD_NEXT)
                   | (cycle == sbsc_pkg::CYC_RD_HOLD);
    assign isWrite = (cycle == sbsc_pkg::CYC_WR_BEGIN) | (cycle == sbsc_pkg::CYC_WR_NEXT)
                   | (cycle == sbsc_pkg::CYC_WR_HOLD);

    // address used by this cycle: external, next or current
    assign burstCnt_nxt = isBegin ? sbsc_pkg::BURST_RST
                        : isNext  ? burstCnt_r + 1'b1
                        : burstCnt_r;
    assign cntUse       = burstCnt_nxt;
    assign accessAddr   = isBegin ? address
                        : {addrHigh_r, burstLow(addrBase_r, cntUse, burstMode)};

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            burstActive_r <= 1'b0;
            addrHigh_r    <= '0;
            addrBase_r    <= sbsc_pkg::BURST_RST;
            burstCnt_r    <= sbsc_pkg::BURST_RST;
        end else begin
            if (isBegin) begin
                addrHigh_r <= address[ADDR_W-1:BURST_W];
                addrBase_r <= address[BURST_W-1:0];
            end
            if (isBegin) begin
                burstActive_r <= 1'b1;
            end else if (cycle == sbsc_pkg::CYC_DESEL || cycle == sbsc_pkg::CYC_SLEEP) begin
                burstActive_r <= 1'b0;
            end
            burstCnt_r <= burstCnt_nxt;
        end
    end

    // writes go through the buffer; the array drains it one entry per clock
    assign wrEntry.addr   = accessAddr;
    assign wrEntry.data   = dataIn;
    assign wrEntry.parity = parityIn;
    assign wrEntry.laneEn = laneEn;
    assign pushValid      = isWrite;
    assign drainReady     = ~sleepLvl_r;
    assign headEntry      = sbsc_pkg::sbsc_wr_t'(headBits);

    sbsc_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (WBUF_DEPTH)
    ) u_wbuf (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .inValid  (pushValid),
        .inReady  (writeBufReady),
        .inData   (wrEntry),
        .outValid (headValid),
        .outReady (drainReady),
        .outData  (headBits)
    );

    always_ff @(posedge core_clk) begin
        for (int l = 0; l < LANES; l++) begin
            if (headValid && drainReady && headEntry.laneEn[l]) begin
                laneMem[l][headEntry.addr]   <= headEntry.data[l*LANE_W +: LANE_W];
                parityMem[l][headEntry.addr] <= headEntry.parity[l];
            end
        end
    end

    // a read right after a write may meet that write still at the buffer head
    assign headHit = headValid & (headEntry.addr == accessAddr);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dataOut_r   <= sbsc_pkg::DATA_RST;
            parityOut_r <= sbsc_pkg::PAR_RST;
        end else if (isRead) begin
            for (int l = 0; l < LANES; l++) begin
                if (headHit && headEntry.laneEn[l]) begin
                    dataOut_r[l*LANE_W +: LANE_W] <= headEntry.data[l*LANE_W +: LANE_W];
                    parityOut_r[l]                <= headEntry.parity[l];
                end else begin
                    dataOut_r[l*LANE_W +: LANE_W] <= laneMem[l][accessAddr];
                    parityOut_r[l]                <= parityMem[l][accessAddr];
                end
            end
        end
    end

    // pins are released unless the last decoded cycle was a read
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            readCycle_r <= 1'b0;
        end else begin
            readCycle_r <= isRead;
        end
    end

    // output enable is never registered, so it releases the pins without waiting for a clock
    assign dataOe    = readCycle_r & ~outputEnableN & ~sleepLvl_r;
    assign parityOe  = dataOe;
    assign dataOut   = dataOut_r;
    assign parityOut = parityOut_r;

endmodule // sbsc_cycle_ctrl

// file: logic/sbsc_fifo.sv
// holds a small first-in first-out buffer with valid/ready on both sides
// assumes one clock; head data are shown ahead while outValid is high
`timescale 1ns/1ps
module sbsc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             arst_n,
    // filling side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // draining side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0]  store [DEPTH];
    logic [PTR_W-1:0]  wrPtr_r;
    logic [PTR_W-1:0]  rdPtr_r;
    logic [PTR_W:0]    count_r;
    logic              push;
    logic              pop;

    assign inReady  = (count_r != (PTR_W+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;
    assign outData  = store[rdPtr_r];

    function automatic logic [PTR_W-1:0] ptrInc(input logic [PTR_W-1:0] p);
        ptrInc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge core_clk) begin
        if (push) begin
            store[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) wrPtr_r <= ptrInc(wrPtr_r);
            if (pop)  rdPtr_r <= ptrInc(rdPtr_r);
            count_r <= count_r + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end

endmodule // sbsc_fifo

// file: logic/sbsc_pkg.sv
// holds the shared constants, cycle types and carrier structs of the burst sram cycle control
// assumes a single core clock; all users reference items as sbsc_pkg::name
package sbsc_pkg;

    // geometry
    localparam int ADDR_W       = 16;
    localparam int LANE_W       = 8;
    localparam int LANES        = 2;
    localparam int DATA_W       = LANE_W * LANES;
    localparam int BURST_W      = 2;

    // write buffer
    localparam int WBUF_DEPTH   = 8;

    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SYNC_STAGES   = 3;

    // reset values
    localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
    localparam logic [DATA_W-1:0]  DATA_RST  = 16'h0000;
    localparam logic [LANES-1:0]   PAR_RST   = 2'h0;

    // cycle types decoded at each clock rise
    typedef enum logic [3:0] {
        CYC_IDLE,
        CYC_DESEL,
        CYC_SLEEP,
        CYC_RD_BEGIN,
        CYC_WR_BEGIN,
        CYC_RD_NEXT,
        CYC_WR_NEXT,
        CYC_RD_HOLD,
        CYC_WR_HOLD
    } sbsc_cycle_t;

    // one buffered write
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0]  parity;
        logic [LANES-1:0]  laneEn;
    } sbsc_wr_t;

endpackage

// file: testbench/sbsc_cycle_ctrl_props.sv
// assertions on cycle decode, pin release and sleep of the burst sram cycle control
// assumes one clock domain; attached to every instance by the bind at the foot
`timescale 1ns/1ps
module sbsc_cycle_ctrl_props (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // selects and sleep
    input wire logic chipSelAN,
    input wire logic chipSelB,
    input wire logic chipSelCN,
    input wire logic sleepRequest,
    // strobes and writes
    input wire logic procAddrStrobe,
    input wire logic ctrlAddrStrobe,
    input wire logic globalWrite,
    input wire logic byteWriteEnableN,
    input wire logic lane0WriteSel,
    input wire logic lane1WriteSel,
    input wire logic outputEnableN,
    // outputs
    input wire logic dataOe,
    input wire logic parityOe,
    input wire logic asleep
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic wrAct;
    logic selOk;
    assign wrAct = !globalWrite || (!byteWriteEnableN && !(lane0WriteSel && lane1WriteSel));
    assign selOk = !chipSelAN && chipSelB && !chipSelCN;
    chk_proc_read_begin: assert property (!asleep && selOk && !procAddrStrobe
        |=> dataOe == (!outputEnableN && !asleep)) else $error("read begin drive wrong");
    chk_ctrl_read_begin: assert property (!asleep && selOk && procAddrStrobe
        && !ctrlAddrStrobe && !wrAct |=> dataOe == (!outputEnableN && !asleep))
        else $error("controller read drive wrong");
    chk_write_begin_quiet: assert property (!asleep && selOk && procAddrStrobe
        && !ctrlAddrStrobe && wrAct |=> !dataOe) else $error("write begin drove pins");
    chk_write_next_quiet: assert property (!asleep && (procAddrStrobe || chipSelAN)
        && ctrlAddrStrobe && wrAct |=> !dataOe) else $error("write continue drove pins");
    chk_desel_select_a: assert property (!asleep && chipSelAN && !ctrlAddrStrobe
        |=> !dataOe) else $error("deselect drove pins");
    chk_desel_bad_sel: assert property (!asleep && !chipSelAN && !procAddrStrobe
        && (!chipSelB || chipSelCN) |=> !dataOe) else $error("bad select drove pins");
    chk_oe_high_release: assert property (outputEnableN |-> !dataOe)
        else $error("pins driven with enable high");
    chk_sleep_release: assert property (asleep |-> !dataOe && !parityOe)
        else $error("pins driven in sleep");
    chk_sleep_entry: assert property (sleepRequest [*5] |-> asleep)
        else $error("sleep not entered");
    chk_sleep_exit: assert property (!sleepRequest [*5] |-> !asleep)
        else $error("sleep not left");
    chk_parity_pin: assert property (parityOe == dataOe)
        else $error("parity drive differs from data drive");
    cov_read: cover property (!procAddrStrobe && selOk ##1 dataOe);
    cov_write: cover property (selOk && !ctrlAddrStrobe && procAddrStrobe && wrAct);
    cov_sleep: cover property (asleep);
endmodule // sbsc_cycle_ctrl_props

bind sbsc_cycle_ctrl sbsc_cycle_ctrl_props u_props (.*);

// file: testbench/sbsc_host_model.sv
// host side of the shared data and parity pins, resolving the wire from both drivers
// assumes the bench says when the host drives; device drive comes from dataOe
`timescale 1ns/1ps
module sbsc_host_model #(
    parameter int W = 18
) (
    // clock
    input  wire logic         core_clk,
    // host drive
    input  wire logic         hostDrive,
    input  wire logic [W-1:0] hostData,
    // device drive
    input  wire logic [W-1:0] devData,
    input  wire logic         devOe,
    // resolved wire
    output logic [W-1:0]      busData,
    output logic              clash
);
    logic [W-1:0] last_r  = '0;
    logic         clash_r = 1'b0;
    // no keeper on these pins: a released bus shows the inverse of its last level
    assign busData = devOe ? devData : (hostDrive ? hostData : ~last_r);
    assign clash   = clash_r;
    always @(posedge core_clk) begin
        last_r <= busData;
        if (devOe && hostDrive) begin
            clash_r <= 1'b1;
        end
    end
endmodule // sbsc_host_model

// file: testbench/testbench.sv
// self-checking bench of the burst sram cycle control with a host pin model
// assumes pins change at the falling edge and results settle 1 ns after the rising edge
`timescale 1ns/1ps
module testbench;
    logic core_clk, arst_n, chipSelAN, chipSelB, chipSelCN, sleepRequest;
    logic procAddrStrobe, ctrlAddrStrobe, burstAdvance, burstMode, globalWrite;
    logic byteWriteEnableN, lane0WriteSel, lane1WriteSel, outputEnableN, hDrive, clash;
    logic [15:0] address, dataOut;
    logic [17:0] hData, bus;
    logic [1:0]  parityOut;
    logic        dataOe, parityOe, writeBufReady, asleep;
    logic [17:0] mem [logic [15:0]];
    int          failures = 0, nChecks = 0, cycles = 0;

    sbsc_cycle_ctrl dut (.core_clk, .arst_n, .chipSelAN, .chipSelB, .chipSelCN,
        .sleepRequest, .address, .procAddrStrobe, .ctrlAddrStrobe, .burstAdvance,
        .burstMode, .globalWrite, .byteWriteEnableN, .lane0WriteSel, .lane1WriteSel,
        .outputEnableN, .dataIn(bus[15:0]), .dataOut, .dataOe, .parityIn(bus[17:16]),
        .parityOut, .parityOe, .writeBufReady, .asleep);
    sbsc_host_model host (.core_clk, .hostDrive(hDrive), .hostData(hData),
        .devData({parityOut, dataOut}), .devOe(dataOe), .busData(bus), .clash);

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic conclude();
        $display("checks %0d failures %0d", nChecks, failures);
        if (failures == 0 && nChecks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            conclude();
        end
    end

    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        nChecks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    function automatic logic wact(input logic [9:0] c);
        return !c[3] || (!c[2] && !(c[1] && c[0]));
    endfunction

    // lane n and its parity bit change only when that lane is written
    function automatic logic [17:0] merge(input logic [17:0] o, d, input logic [9:0] c);
        logic m0, m1;
        m0 = !c[3] || (!c[2] && !c[1]);
        m1 = !c[3] || (!c[2] && !c[0]);
        return {m1 ? d[17] : o[17], m0 ? d[16] : o[16],
                m1 ? d[15:8] : o[15:8], m0 ? d[7:0] : o[7:0]};
    endfunction

    // c packs selects a,b,c then strobes, advance and write controls, as on the pins
    task automatic cyc(input logic [9:0] c, input logic o, input logic [15:0] a,
                       input logic [17:0] d);
        @(negedge core_clk);
        {chipSelAN, chipSelB, chipSelCN, procAddrStrobe, ctrlAddrStrobe, burstAdvance,
         globalWrite, byteWriteEnableN, lane0WriteSel, lane1WriteSel} = c;
        outputEnableN = o;
        address = a;
        hData = d;
        hDrive = wact(c) && c[6];
        @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [9:0] c, input logic o, input logic [15:0] a, k,
                      input logic [17:0] d);
        cyc(c, o, a, d);
        mem[k] = merge(mem[k], d, c);
        check(dataOe, 1'b0);
    endtask

    task automatic rd(input logic [9:0] c, input logic o, input logic [15:0] a, k);
        cyc(c, o, a, 18'h00000);
        check({parityOut, dataOut}, mem[k]);
        check(dataOe, !o);
    endtask

    task automatic t_linear();
        wr(10'h157, 1'b1, 16'h0011, 16'h0011, 18'h10011);
        wr(10'h167, 1'b0, 16'h0000, 16'h0012, 18'h20012);
        wr(10'h177, 1'b0, 16'h0000, 16'h0012, 18'h0A5A5);
        wr(10'h167, 1'b1, 16'h0000, 16'h0013, 18'h35AA3);
        wr(10'h167, 1'b1, 16'h0000, 16'h0010, 18'h0F00F);
        rd(10'h13F, 1'b0, 16'h0011, 16'h0011);
        rd(10'h16F, 1'b0, 16'h0000, 16'h0012);
        rd(10'h17F, 1'b0, 16'h0000, 16'h0012);
        rd(10'h16F, 1'b1, 16'h0000, 16'h0013);
        rd(10'h16F, 1'b0, 16'h0000, 16'h0010);
    endtask

    task automatic t_interleave();
        @(negedge core_clk);
        burstMode = 1'b1;
        wr(10'h157, 1'b1, 16'h0032, 16'h0032, 18'h13232);
        wr(10'h167, 1'b1, 16'h0000, 16'h0033, 18'h23333);
        wr(10'h167, 1'b1, 16'h0000, 16'h0030, 18'h03030);
        wr(10'h167, 1'b1, 16'h0000, 16'h0031, 18'h33131);
        rd(10'h13F, 1'b0, 16'h0031, 16'h0031);
        rd(10'h16F, 1'b0, 16'h0000, 16'h0030);
        rd(10'h16F, 1'b0, 16'h0000, 16'h0033);
        rd(10'h16F, 1'b0, 16'h0000, 16'h0032);
    endtask

    task automatic t_lanes();
        wr(10'h157, 1'b1, 16'h0040, 16'h0040, 18'h3FFFF);
        wr(10'h179, 1'b1, 16'h0000, 16'h0040, 18'h01234);
        wr(10'h17A, 1'b1, 16'h0000, 16'h0040, 18'h2ABCD);
        rd(10'h15B, 1'b0, 16'h0040, 16'h0040);
        rd(10'h15C, 1'b0, 16'h0040, 16'h0040);
        rd(10'h137, 1'b0, 16'h0040, 16'h0040);
    endtask

    task automatic t_desel();
        cyc(10'h03F, 1'b0, 16'h0011, 18'h00000);
        check(dataOe, 1'b0);
        rd(10'h13F, 1'b0, 16'h0011, 16'h0011);
        rd(10'h32F, 1'b0, 16'h0000, 16'h0010);
        cyc(10'h35B, 1'b0, 16'h0000, 18'h00000);
        check(dataOe, 1'b0);
        cyc(10'h16F, 1'b0, 16'h0000, 18'h00000);
        check(dataOe, 1'b0);
    endtask

    task automatic t_sleep();
        @(negedge core_clk);
        sleepRequest = 1'b1;
        repeat (5) cyc(10'h17F, 1'b1, 16'h0000, 18'h00000);
        check(asleep, 1'b1);
        cyc(10'h157, 1'b1, 16'h0011, 18'h3FFFF);
        cyc(10'h13F, 1'b0, 16'h0011, 18'h00000);
        check(dataOe, 1'b0);
        @(negedge core_clk);
        sleepRequest = 1'b0;
        repeat (5) cyc(10'h17F, 1'b1, 16'h0000, 18'h00000);
        check(asleep, 1'b0);
        rd(10'h13F, 1'b0, 16'h0011, 16'h0011);
    endtask

    initial begin
        arst_n = 1'b0;
        {chipSelAN, chipSelB, chipSelCN, sleepRequest, burstMode} = 5'h08;
        {procAddrStrobe, ctrlAddrStrobe, burstAdvance, globalWrite} = 4'hF;
        {byteWriteEnableN, lane0WriteSel, lane1WriteSel, outputEnableN} = 4'hF;
        {address, hDrive, hData} = '0;
        repeat (3) @(negedge core_clk);
        arst_n = 1'b1;
        t_linear();
        t_interleave();
        t_lanes();
        t_desel();
        t_sleep();
        check(clash, 1'b0);
        check(writeBufReady, 1'b1);
        conclude();
    end
endmodule // testbench
